// ===== verilog/scr_sensor_regs.sv
// Purpose: Frame activity, soft reset, shutdown, id complement and burst readout
//          registers of a motion sensor, reached over the four-wire serial port.
// Assumes: Imaging engine supplies motion data, a frame pulse and the power mode
//          on clk_in; serial pins are asynchronous to clk_in.
// Notes:   One transaction is an address byte followed by data bytes.
// Function
// - Report the power mode as two bits: run, rest one, rest two, rest three.
// - Set the five frame activity bits on every captured frame outside shutdown.
// - Any write to the observation register clears the frame activity bits.
// - Writing 0x5A to the soft reset register resets the device.
// - Soft reset returns every setting to its default value.
// - Writing 0xE7 to the power down register enters shutdown.
// - Two read-only registers return inverted revision and part codes.
// - Reading the burst register starts streaming bytes without new addresses.
// - Burst order: status, X, Y, quality, shutter high, shutter low, max pixel.
// - Accumulated motion is cleared once three burst bytes are read.
// - Burst may end at any byte boundary after X without error.
`timescale 1ns/10ps
module scr_sensor_regs
  import scr_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h12,  // Arbitrary value
  parameter logic [7:0] PART_CODE     = 8'h34   // Arbitrary value
)(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ncs_n_in,
  input  wire logic        sclk_in,
  input  wire logic        mosi_in,
  input  wire logic        frame_strobe_in,
  input  wire logic [1:0]  power_mode_in,
  input  wire logic [7:0]  motion_status_in,
  input  wire logic [7:0]  delta_x_in,
  input  wire logic [7:0]  delta_y_in,
  input  wire logic [7:0]  surface_quality_in,
  input  wire logic [15:0] shutter_in,
  input  wire logic [7:0]  max_pixel_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  output logic             motion_clear_out,
  output logic             soft_reset_out,
  output logic             shutdown_out
);

  // ==========================================================================
  // Serial port
  // ==========================================================================
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic       sel;
  logic [7:0] tx_q;

  scr_spi_shifter u_shifter (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .ncs_n_in     (ncs_n_in),
    .sclk_in      (sclk_in),
    .mosi_in      (mosi_in),
    .tx_data_in   (tx_q),
    .rx_data_out  (rx_byte),
    .rx_valid_out (rx_valid),
    .sel_out      (sel),
    .miso_out     (miso_out),
    .miso_oe_out  (miso_oe_out)
  );

  // ==========================================================================
  // Reset tree
  // ==========================================================================
  logic soft_reset_q;
  logic cfg_rst;

  // Soft reset reaches every setting but not the serial engine itself,
  // so the frame that carried the command finishes cleanly
  assign cfg_rst        = !rst_n_in || soft_reset_q;
  assign soft_reset_out = soft_reset_q;

  // ==========================================================================
  // Write decode
  // ==========================================================================
  scr_state_t state_q;
  logic [6:0] addr_q;
  logic       wr_stb;
  logic       obs_clear;
  logic       rst_cmd;
  logic       pd_cmd;

  assign wr_stb    = rx_valid && sel && (state_q == SCR_ST_WDATA);
  assign obs_clear = wr_stb && (addr_q == SCR_ADDR_FRAME_ACT);
  assign rst_cmd   = wr_stb && (addr_q == SCR_ADDR_SOFT_RST)
                     && (rx_byte == SCR_SOFT_RST_CODE);
  assign pd_cmd    = wr_stb && (addr_q == SCR_ADDR_PWR_DOWN)
                     && (rx_byte == SCR_PWR_DOWN_CODE);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= rst_cmd;
    end
  end

  // Only soft reset or hardware reset wakes the device; no other write clears this
  always_ff @(posedge clk_in) begin
    if (cfg_rst) begin
      shutdown_out <= 1'b0;
    end else if (pd_cmd) begin
      shutdown_out <= 1'b1;
    end
  end

  // ==========================================================================
  // Frame activity bits
  // ==========================================================================
  logic [4:0] frame_toggle_bits_q;

  // A frame in the clearing cycle wins, so no frame outside shutdown is missed
  always_ff @(posedge clk_in) begin
    if (cfg_rst) begin
      frame_toggle_bits_q <= SCR_FRAME_RST;
    end else if (frame_strobe_in && !shutdown_out) begin
      frame_toggle_bits_q <= SCR_FRAME_SET;
    end else if (obs_clear) begin
      frame_toggle_bits_q <= SCR_FRAME_RST;
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  function automatic logic [7:0] scr_read_value(input logic [6:0] addr,
                                                input logic [1:0] mode,
                                                input logic [4:0] frame_bits);
    logic [7:0] val;
    val = SCR_IDLE_BYTE;
    case (addr)
      SCR_ADDR_FRAME_ACT: val = {mode, 1'b0, frame_bits};
      SCR_ADDR_REV_CMP:   val = ~REVISION_CODE;
      SCR_ADDR_PART_CMP:  val = ~PART_CODE;
      default:            val = SCR_IDLE_BYTE;
    endcase
    return val;
  endfunction

  // ==========================================================================
  // Transaction sequencer and burst readout
  // ==========================================================================
  logic [7:0] burst_snap_q [7];
  logic [2:0] burst_idx_q;
  logic       burst_start;

  assign burst_start = rx_valid && sel && (state_q == SCR_ST_ADDR)
                       && !rx_byte[SCR_WRITE_BIT]
                       && (rx_byte[6:0] == SCR_ADDR_BURST);

  // Snapshot keeps the seven bytes coherent while motion is cleared midway
  always_ff @(posedge clk_in) begin
    if (burst_start) begin
      burst_snap_q[0] <= motion_status_in;
      burst_snap_q[1] <= delta_x_in;
      burst_snap_q[2] <= delta_y_in;
      burst_snap_q[3] <= surface_quality_in;
      burst_snap_q[4] <= shutter_in[15:8];
      burst_snap_q[5] <= shutter_in[7:0];
      burst_snap_q[6] <= max_pixel_in;
    end
  end

  // Deselect always returns to the address phase, ending a burst anywhere
  always_ff @(posedge clk_in) begin
    if (cfg_rst || !sel) begin
      state_q     <= SCR_ST_ADDR;
      addr_q      <= 7'h00;
      burst_idx_q <= 3'h0;
      tx_q        <= SCR_IDLE_BYTE;
    end else if (rx_valid) begin
      case (state_q)
        SCR_ST_ADDR: begin
          addr_q <= rx_byte[6:0];
          if (rx_byte[SCR_WRITE_BIT]) begin
            state_q <= SCR_ST_WDATA;
            tx_q    <= SCR_IDLE_BYTE;
          end else if (rx_byte[6:0] == SCR_ADDR_BURST) begin
            state_q     <= SCR_ST_BURST;
            burst_idx_q <= 3'h1;
            tx_q        <= motion_status_in;
          end else begin
            state_q <= SCR_ST_RDATA;
            tx_q    <= scr_read_value(rx_byte[6:0], power_mode_in,
                                      frame_toggle_bits_q);
          end
        end
        SCR_ST_WDATA: begin
          state_q <= SCR_ST_ADDR;
          tx_q    <= SCR_IDLE_BYTE;
        end
        SCR_ST_RDATA: begin
          state_q <= SCR_ST_ADDR;
          tx_q    <= SCR_IDLE_BYTE;
        end
        SCR_ST_BURST: begin
          if (burst_idx_q < SCR_BURST_LEN) begin
            tx_q        <= burst_snap_q[burst_idx_q];
            burst_idx_q <= burst_idx_q + 3'h1;
          end else begin
            tx_q <= SCR_IDLE_BYTE;
          end
        end
        default: begin
          state_q <= SCR_ST_ADDR;
          tx_q    <= SCR_IDLE_BYTE;
        end
      endcase
    end
  end

  // Pulse after the third burst byte has fully left the port
  always_ff @(posedge clk_in) begin
    if (cfg_rst) begin
      motion_clear_out <= 1'b0;
    end else begin
      motion_clear_out <= rx_valid && sel && (state_q == SCR_ST_BURST)
                          && (burst_idx_q == SCR_BURST_CLR_AT);
    end
  end

endmodule // scr_sensor_regs

// ===== verilog/scr_pkg.sv
// Purpose: Shared constants and types for the sensor control register block.
// Assumes: Registers are reached only through the four-wire serial port.
// Notes:   Address byte bit 7 set means write, clear means read.
package scr_pkg;

  // ==========================================================================
  // Serial framing
  // ==========================================================================
  localparam int          SCR_BYTE_W       = 8;
  localparam int          SCR_ADDR_W       = 7;
  localparam int          SCR_SYNC_STAGES  = 2;
  localparam int          SCR_WRITE_BIT    = 7;
  localparam logic [2:0]  SCR_LAST_BIT     = 3'h7;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [6:0]  SCR_ADDR_FRAME_ACT = 7'h2E;
  localparam logic [6:0]  SCR_ADDR_SOFT_RST  = 7'h3A;
  localparam logic [6:0]  SCR_ADDR_PWR_DOWN  = 7'h3B;
  localparam logic [6:0]  SCR_ADDR_REV_CMP   = 7'h3E;
  localparam logic [6:0]  SCR_ADDR_PART_CMP  = 7'h3F;
  localparam logic [6:0]  SCR_ADDR_BURST     = 7'h42;

  // ==========================================================================
  // Command codes and field layout
  // ==========================================================================
  localparam logic [7:0]  SCR_SOFT_RST_CODE  = 8'h5A;
  localparam logic [7:0]  SCR_PWR_DOWN_CODE  = 8'hE7;
  localparam int          SCR_FRAME_BITS_W   = 5;
  localparam int          SCR_MODE_LSB       = 6;
  localparam logic [4:0]  SCR_FRAME_SET      = 5'h1F;
  localparam logic [4:0]  SCR_FRAME_RST      = 5'h00;
  localparam logic [7:0]  SCR_IDLE_BYTE      = 8'h00;

  // Power mode encodings
  localparam logic [1:0]  SCR_MODE_RUN       = 2'h0;
  localparam logic [1:0]  SCR_MODE_REST1     = 2'h1;
  localparam logic [1:0]  SCR_MODE_REST2     = 2'h2;
  localparam logic [1:0]  SCR_MODE_REST3     = 2'h3;

  // ==========================================================================
  // Burst readout
  // ==========================================================================
  localparam logic [2:0]  SCR_BURST_LEN      = 3'h7;
  localparam logic [2:0]  SCR_BURST_CLR_AT   = 3'h3;

  typedef enum logic [1:0] {
    SCR_ST_ADDR  = 2'b00,
    SCR_ST_WDATA = 2'b01,
    SCR_ST_RDATA = 2'b10,
    SCR_ST_BURST = 2'b11
  } scr_state_t;

endpackage

// ===== verilog/scr_spi_shifter.sv
// Purpose: Byte engine for the four-wire serial port, sampled on clk_in.
// Assumes: Serial clock idles high, data sampled on its rising edge, MSB first.
// Notes:   Serial clock must be no faster than an eighth of clk_in.
`timescale 1ns/10ps
module scr_spi_shifter
  import scr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ncs_n_in,
  input  wire logic       sclk_in,
  input  wire logic       mosi_in,
  input  wire logic [7:0] tx_data_in,
  output logic      [7:0] rx_data_out,
  output logic            rx_valid_out,
  output logic            sel_out,
  output logic            miso_out,
  output logic            miso_oe_out
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] sclk_sync_q;
  logic [1:0] ncs_sync_q;
  logic [1:0] mosi_sync_q;
  logic       sclk_rise;
  logic       sclk_fall;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_sync_q <= 3'h7;
      ncs_sync_q  <= 2'h3;
      mosi_sync_q <= 2'h0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
      ncs_sync_q  <= {ncs_sync_q[0], ncs_n_in};
      mosi_sync_q <= {mosi_sync_q[0], mosi_in};
    end
  end

  // Edge detection looks only at the second stage and its delayed copy
  assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign sel_out   = ~ncs_sync_q[1];

  // ==========================================================================
  // Shift registers
  // ==========================================================================
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_shift_q;
  logic [7:0] tx_shift_q;
  logic       load_pending_q;

  // Deselect drops any partial byte, so an early end of frame is harmless
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !sel_out) begin
      bit_cnt_q      <= 3'h0;
      rx_shift_q     <= 8'h00;
      tx_shift_q     <= 8'h00;
      load_pending_q <= 1'b0;
      rx_valid_out   <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      if (sclk_rise) begin
        rx_shift_q <= {rx_shift_q[6:0], mosi_sync_q[1]};
        bit_cnt_q  <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == SCR_LAST_BIT) begin
          rx_valid_out   <= 1'b1;
          load_pending_q <= 1'b1;
        end
      end
      if (sclk_fall) begin
        if (load_pending_q) begin
          tx_shift_q     <= tx_data_in;
          load_pending_q <= 1'b0;
        end else begin
          tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rx_data_out <= 8'h00;
    end else if (sel_out && sclk_rise && bit_cnt_q == SCR_LAST_BIT) begin
      rx_data_out <= {rx_shift_q[6:0], mosi_sync_q[1]};
    end
  end

  assign miso_out    = tx_shift_q[7];
  assign miso_oe_out = sel_out;

endmodule // scr_spi_shifter

// ===== verification/scr_regs_chk.sv
// Purpose: Port assertions for the sensor control register block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound into every scr_sensor_regs instance.
`timescale 1ns/10ps
module scr_regs_chk (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic ncs_n_in,
  input  wire logic miso_oe_out,
  input  wire logic motion_clear_out,
  input  wire logic soft_reset_out,
  input  wire logic shutdown_out
);
  // ==========================================
  // Properties
  // ==========================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_oe_idle_low: assert property (ncs_n_in [*3] |-> !miso_oe_out)
    else $error("data out driven while deselected");
  chk_oe_on_select: assert property ($fell(ncs_n_in) |-> ##[1:4] miso_oe_out)
    else $error("data out not driven after select");
  chk_reset_pulse: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset longer than one cycle");
  chk_reset_in_frame: assert property (soft_reset_out |-> !ncs_n_in)
    else $error("soft reset outside a serial frame");
  chk_reset_wakes: assert property (soft_reset_out |=> !shutdown_out)
    else $error("shutdown survives soft reset");
  chk_shut_holds: assert property (shutdown_out && !soft_reset_out |=> shutdown_out)
    else $error("shutdown left without soft reset");
  chk_shut_in_frame: assert property ($rose(shutdown_out) |-> !ncs_n_in)
    else $error("shutdown entered outside a serial frame");
  chk_clear_pulse: assert property (motion_clear_out |=> !motion_clear_out)
    else $error("motion clear longer than one cycle");
  chk_clear_in_frame: assert property (motion_clear_out |-> !ncs_n_in)
    else $error("motion clear outside a serial frame");
endmodule // scr_regs_chk

bind scr_sensor_regs scr_regs_chk u_chk (
  .clk_in           (clk_in),
  .rst_n_in         (rst_n_in),
  .ncs_n_in         (ncs_n_in),
  .miso_oe_out      (miso_oe_out),
  .motion_clear_out (motion_clear_out),
  .soft_reset_out   (soft_reset_out),
  .shutdown_out     (shutdown_out)
);

// ===== verification/scr_host_model.sv
// Purpose: Behavioural microcontroller on the four-wire serial port.
// Assumes: Serial clock idles high; the device samples on its rising edge.
// Notes:   Half period of 8 cycles doubles the minimum the port needs.
`timescale 1ns/10ps
module scr_host_model (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      ncs_n_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  localparam int HALF = 8;

  initial begin
    ncs_n_out = 1'b1;
    sclk_out  = 1'b1;
    mosi_out  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Select or release; a released data line must not keep its last bit
  task automatic select(input logic on);
    wait_clk(HALF);
    ncs_n_out <= ~on;
    if (!on) mosi_out <= ~mosi_out;
    wait_clk(HALF);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      wait_clk(HALF);
      sclk_out <= 1'b0;
      mosi_out <= tx[i];
      wait_clk(HALF);
      sclk_out <= 1'b1;
      rx[i] = miso_in;
    end
  endtask
endmodule // scr_host_model

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the sensor control register block.
// Assumes: Host model drives the serial pins; bench drives the sensor side.
// Notes:   Whole run is about 7300 cycles; watchdog allows 30000.
`timescale 1ns/10ps
module tb_top;
  import scr_pkg::*;
  localparam logic [7:0] REV  = 8'hA5; // Arbitrary
  localparam logic [7:0] PART = 8'h3C; // Arbitrary
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        fstrobe  = 1'b0;
  logic [1:0]  pmode    = 2'h0;
  logic [7:0]  mstat    = 8'h81;
  logic [7:0]  dx       = 8'h12;
  logic [7:0]  dy       = 8'hF3;
  logic [7:0]  squal    = 8'h44;
  logic [15:0] shutter  = 16'hBE0F;
  logic [7:0]  maxpix   = 8'h7E;
  wire         ncs_n, sclk, mosi, miso, miso_oe, mclr, srst, shut;
  wire         miso_w   = miso_oe ? miso : 1'b1;
  int          err_total = 0, comparisons = 0, n_clr = 0, n_srst = 0;
  logic [7:0]  v;
  logic [7:0]  exp_b [8];

  always #20 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (mclr === 1'b1) n_clr <= n_clr + 1;
    if (srst === 1'b1) n_srst <= n_srst + 1;
  end

  scr_sensor_regs #(.REVISION_CODE(REV), .PART_CODE(PART)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ncs_n_in(ncs_n), .sclk_in(sclk),
    .mosi_in(mosi), .frame_strobe_in(fstrobe), .power_mode_in(pmode),
    .motion_status_in(mstat), .delta_x_in(dx), .delta_y_in(dy),
    .surface_quality_in(squal), .shutter_in(shutter), .max_pixel_in(maxpix),
    .miso_out(miso), .miso_oe_out(miso_oe), .motion_clear_out(mclr),
    .soft_reset_out(srst), .shutdown_out(shut));

  scr_host_model u_host (.clk_in(clk_in), .miso_in(miso_w), .ncs_n_out(ncs_n),
    .sclk_out(sclk), .mosi_out(mosi));

  // ==========================================
  // Tasks
  // ==========================================
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    u_host.select(1'b1);
    u_host.xfer({1'b1, a}, rx);
    u_host.xfer(d, rx);
    u_host.select(1'b0);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    logic [7:0] rx;
    u_host.select(1'b1);
    u_host.xfer({1'b0, a}, rx);
    u_host.xfer(8'h00, d);
    u_host.select(1'b0);
  endtask

  task automatic frame_pulse;
    @(posedge clk_in) fstrobe <= 1'b1;
    @(posedge clk_in) fstrobe <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // Tests
  // ==========================================
  initial begin
    exp_b = '{8'h81, 8'h12, 8'hF3, 8'h44, 8'hBE, 8'h0F, 8'h7E, 8'h00};
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(SCR_ADDR_REV_CMP, v);  check(v, ~REV);
    rd(SCR_ADDR_PART_CMP, v); check(v, ~PART);
    rd(7'h10, v);             check(v, 8'h00);
    $display("Test id done");
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_in) pmode <= 2'(m);
      rd(SCR_ADDR_FRAME_ACT, v); check(v, {2'(m), 6'h00});
    end
    frame_pulse();
    rd(SCR_ADDR_FRAME_ACT, v); check(v, 8'hDF);
    wr(SCR_ADDR_FRAME_ACT, 8'hA5);
    rd(SCR_ADDR_FRAME_ACT, v); check(v, 8'hC0);
    $display("Test observation done");
    u_host.select(1'b1);
    u_host.xfer({1'b0, SCR_ADDR_BURST}, v);
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(8'h00, v);
      check(v, exp_b[i]);
      if (i == 1) check(8'(n_clr), 8'h00);
      if (i == 3) check(8'(n_clr), 8'h01);
    end
    u_host.select(1'b0);
    // New sensor values, so a stale snapshot cannot pass the later bursts
    @(posedge clk_in);
    mstat   <= 8'h02;
    dx      <= 8'h5B;
    dy      <= 8'hC1;
    squal   <= 8'h27;
    shutter <= 16'h0A3D;
    maxpix  <= 8'h19;
    // Stop right after the X byte
    u_host.select(1'b1);
    u_host.xfer({1'b0, SCR_ADDR_BURST}, v);
    u_host.xfer(8'h00, v);
    check(v, 8'h02);
    u_host.xfer(8'h00, v);
    check(v, 8'h5B);
    u_host.select(1'b0);
    check(8'(n_clr), 8'h01);
    rd(SCR_ADDR_REV_CMP, v);  check(v, ~REV);
    // Full burst again with the new values
    exp_b = '{8'h02, 8'h5B, 8'hC1, 8'h27, 8'h0A, 8'h3D, 8'h19, 8'h00};
    u_host.select(1'b1);
    u_host.xfer({1'b0, SCR_ADDR_BURST}, v);
    for (int i = 0; i < 7; i++) begin
      u_host.xfer(8'h00, v);
      check(v, exp_b[i]);
    end
    u_host.select(1'b0);
    check(8'(n_clr), 8'h02);
    $display("Test burst done");
    frame_pulse();
    wr(SCR_ADDR_PWR_DOWN, 8'h55);     check({7'h00, shut}, 8'h00);
    wr(SCR_ADDR_PWR_DOWN, SCR_PWR_DOWN_CODE); check({7'h00, shut}, 8'h01);
    wr(SCR_ADDR_SOFT_RST, 8'h00);     check({7'h00, shut}, 8'h01);
    check(8'(n_srst), 8'h00);
    wr(SCR_ADDR_SOFT_RST, SCR_SOFT_RST_CODE); check(8'(n_srst), 8'h01);
    check({7'h00, shut}, 8'h00);
    rd(SCR_ADDR_FRAME_ACT, v); check(v, 8'hC0);
    $display("Test commands done");
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // tb_top
